// [pkg/interlock_diag_pkg.sv]
// constants and types for the guard-locking interlock diagnostic controller
package interlock_diag_pkg;

  // ----------------------------------------
  // timebase
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_NS = 1_000_000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 18;

  // ----------------------------------------
  // delays and flash timing, in milliseconds
  // ----------------------------------------
  localparam int WARN_DELAY_MIN = 30;
  localparam int WARN_DELAY_MS = WARN_DELAY_MIN * 60 * 1000;
  localparam int DELAY_W = 21;
  localparam int RED_HALF_MS = 250;
  localparam int YEL_FLASH_HZ = 3;
  localparam int YEL_HALF_MS = 1000 / (2 * YEL_FLASH_HZ);
  localparam int MS_W = 10;
  localparam int PAUSE_STEPS = 4;
  localparam int STEP_W = 5;

  // ----------------------------------------
  // input bit positions after synchronising
  // ----------------------------------------
  localparam int IN_W = 11;
  localparam int SY_ACT = 0;
  localparam int SY_TGT = 1;
  localparam int SY_COND = 2;
  localparam int SY_NEAR = 3;
  localparam int SY_FAIL_A = 4;
  localparam int SY_FAIL_B = 5;
  localparam int SY_CROSS = 6;
  localparam int SY_TEMP = 7;
  localparam int SY_BAD_ACT = 8;
  localparam int SY_BAD_COMBO = 9;
  localparam int SY_INTERNAL = 10;

  // ----------------------------------------
  // red flash codes (pulse count, 7 = steady)
  // ----------------------------------------
  typedef logic [2:0] code_t;
  localparam code_t CODE_NONE = 3'h0;
  localparam code_t CODE_OUT_A = 3'h1;
  localparam code_t CODE_OUT_B = 3'h2;
  localparam code_t CODE_CROSS = 3'h3;
  localparam code_t CODE_TEMP = 3'h4;
  localparam code_t CODE_BAD_ACT = 3'h5;
  localparam code_t CODE_BAD_COMBO = 3'h6;
  localparam code_t CODE_INTERNAL = 3'h7;

  // ----------------------------------------
  // fault manager states
  // ----------------------------------------
  typedef enum logic [3:0] {
    S_RUN = 4'h1,
    S_WARN = 4'h2,
    S_FAIL = 4'h4,
    S_REARM = 4'h8
  } state_t;

endpackage

// [rtl/interlock_diag_controller.sv]
// supervisory output, lamp and fault logic of a guard-locking switch
`timescale 1ns/10ps
`default_nettype none

module interlock_diag_controller
  import interlock_diag_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int WARN_MS = WARN_DELAY_MS
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // sensor detections
  input wire logic i_actuator_det,
  input wire logic i_lock_target_det,
  input wire logic i_lock_cond_det,
  input wire logic i_near_limit,
  // self-test results
  input wire logic i_test_fail_a,
  input wire logic i_test_fail_b,
  input wire logic i_cross_wire,
  input wire logic i_over_temp,
  input wire logic i_bad_actuator,
  input wire logic i_bad_target_combo,
  input wire logic i_internal_err,
  // safety outputs
  output logic o_primary_safe_out_a,
  output logic o_primary_safe_out_b,
  output logic o_lock_path_out_a,
  output logic o_lock_path_out_b,
  // diagnostic output and lamps
  output logic o_diag_out,
  output logic o_led_green,
  output logic o_led_yellow,
  output logic o_led_red
);

  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  if (TICK_CYC < 2 || TICK_CYC > 2 ** TICK_W) begin : g_bad_tick
    $error("TICK_CYC out of range");
  end
  if (WARN_MS < 1 || WARN_MS > 2 ** DELAY_W) begin : g_bad_warn
    $error("WARN_MS out of range");
  end

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [IN_W-1:0] raw_in;
  logic [IN_W-1:0] sync1_ff;
  logic [IN_W-1:0] sync2_ff;

  assign raw_in = {i_internal_err, i_bad_target_combo, i_bad_actuator,
                   i_over_temp, i_cross_wire, i_test_fail_b, i_test_fail_a,
                   i_near_limit, i_lock_cond_det, i_lock_target_det,
                   i_actuator_det};

  for (genvar gi = 0; gi < IN_W; gi++) begin : g_sync
    always_ff @(posedge i_clk) begin
      if (i_srst) begin
        sync1_ff[gi] <= 1'b0;
        sync2_ff[gi] <= 1'b0;
      end else begin
        sync1_ff[gi] <= raw_in[gi];
        sync2_ff[gi] <= sync1_ff[gi];
      end
    end
  end

  logic act_s;
  logic locked_s;
  logic crit_s;
  logic warn_s;
  logic fault_s;

  assign act_s = sync2_ff[SY_ACT];
  assign locked_s = sync2_ff[SY_ACT] & sync2_ff[SY_TGT] & sync2_ff[SY_COND];
  // immediate switch-off causes
  assign crit_s = sync2_ff[SY_INTERNAL] | sync2_ff[SY_BAD_ACT] |
                  sync2_ff[SY_BAD_COMBO];
  // delayed switch-off causes
  assign warn_s = sync2_ff[SY_FAIL_A] | sync2_ff[SY_FAIL_B] |
                  sync2_ff[SY_CROSS] | sync2_ff[SY_TEMP];
  assign fault_s = crit_s | warn_s;

  // ----------------------------------------
  // live fault code, highest priority first
  // ----------------------------------------
  code_t live_code;

  always_comb begin
    if (sync2_ff[SY_INTERNAL]) begin
      live_code = CODE_INTERNAL;
    end else if (sync2_ff[SY_BAD_COMBO]) begin
      live_code = CODE_BAD_COMBO;
    end else if (sync2_ff[SY_BAD_ACT]) begin
      live_code = CODE_BAD_ACT;
    end else if (sync2_ff[SY_CROSS] ||
                 (sync2_ff[SY_FAIL_A] && sync2_ff[SY_FAIL_B])) begin
      live_code = CODE_CROSS;
    end else if (sync2_ff[SY_FAIL_A]) begin
      live_code = CODE_OUT_A;
    end else if (sync2_ff[SY_FAIL_B]) begin
      live_code = CODE_OUT_B;
    end else if (sync2_ff[SY_TEMP]) begin
      live_code = CODE_TEMP;
    end else begin
      live_code = CODE_NONE;
    end
  end

  // ----------------------------------------
  // millisecond timebase
  // ----------------------------------------
  logic [TICK_W-1:0] tick_cnt_ff;
  logic tick;

  assign tick = (tick_cnt_ff == TICK_W'(TICK_CYC - 1));

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tick_cnt_ff <= '0;
    end else if (tick) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + TICK_W'(1);
    end
  end

  // ----------------------------------------
  // fault manager
  // ----------------------------------------
  state_t state_ff;
  state_t nxt_state;
  code_t code_ff;
  code_t nxt_code;
  logic [DELAY_W-1:0] delay_cnt_ff;
  logic delay_done;

  assign delay_done = tick && (delay_cnt_ff == DELAY_W'(WARN_MS - 1));

  always_comb begin
    nxt_state = state_ff;
    nxt_code = code_ff;
    unique case (state_ff)
      S_RUN: begin
        if (crit_s) begin
          nxt_state = S_FAIL;
          nxt_code = live_code;
        end else if (warn_s) begin
          nxt_state = S_WARN;
          nxt_code = live_code;
        end
      end
      S_WARN: begin
        if (crit_s) begin
          nxt_state = S_FAIL;
          nxt_code = live_code;
        end else if (!warn_s) begin
          nxt_state = S_RUN;
          nxt_code = CODE_NONE;
        end else if (delay_done) begin
          nxt_state = S_FAIL;
        end else begin
          nxt_code = live_code;
        end
      end
      S_FAIL: begin
        if (!fault_s && !act_s) begin
          nxt_state = S_REARM;
        end
      end
      S_REARM: begin
        if (fault_s) begin
          nxt_state = S_FAIL;
          nxt_code = live_code;
        end else if (act_s) begin
          nxt_state = S_RUN;
          nxt_code = CODE_NONE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_ff <= S_RUN;
      code_ff <= CODE_NONE;
    end else begin
      state_ff <= nxt_state;
      code_ff <= nxt_code;
    end
  end

  // thirty minute warning delay
  always_ff @(posedge i_clk) begin
    if (i_srst || state_ff != S_WARN) begin
      delay_cnt_ff <= '0;
    end else if (tick) begin
      delay_cnt_ff <= delay_cnt_ff + DELAY_W'(1);
    end
  end

  // ----------------------------------------
  // flash generators
  // ----------------------------------------
  logic [MS_W-1:0] red_ms_ff;
  logic [STEP_W-1:0] step_ff;
  logic [STEP_W-1:0] step_last;
  logic [MS_W-1:0] yel_ms_ff;
  logic yel_phase_ff;
  logic red_flash;

  assign step_last = STEP_W'({code_ff, 1'b0}) + STEP_W'(PAUSE_STEPS - 1);
  assign red_flash = (step_ff < STEP_W'({code_ff, 1'b0})) && !step_ff[0];

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      red_ms_ff <= '0;
      step_ff <= '0;
    end else if (tick) begin
      if (red_ms_ff == MS_W'(RED_HALF_MS - 1)) begin
        red_ms_ff <= '0;
        if (step_ff >= step_last) begin
          step_ff <= '0;
        end else begin
          step_ff <= step_ff + STEP_W'(1);
        end
      end else begin
        red_ms_ff <= red_ms_ff + MS_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      yel_ms_ff <= '0;
      yel_phase_ff <= 1'b0;
    end else if (tick) begin
      if (yel_ms_ff == MS_W'(YEL_HALF_MS - 1)) begin
        yel_ms_ff <= '0;
        yel_phase_ff <= !yel_phase_ff;
      end else begin
        yel_ms_ff <= yel_ms_ff + MS_W'(1);
      end
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  logic fail_nxt;
  logic fail_now;
  logic path2_nxt;

  assign fail_nxt = (nxt_state == S_FAIL) || (nxt_state == S_REARM);
  assign fail_now = (state_ff == S_FAIL) || (state_ff == S_REARM);
  assign path2_nxt = locked_s && !fail_nxt;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_primary_safe_out_a <= 1'b0;
      o_primary_safe_out_b <= 1'b0;
      o_lock_path_out_a <= 1'b0;
      o_lock_path_out_b <= 1'b1;
      o_diag_out <= 1'b0;
    end else begin
      o_primary_safe_out_a <= act_s && !fail_nxt;
      o_primary_safe_out_b <= act_s && !fail_nxt;
      o_lock_path_out_a <= path2_nxt;
      o_lock_path_out_b <= !path2_nxt;
      o_diag_out <= path2_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_led_green <= 1'b0;
      o_led_yellow <= 1'b0;
      o_led_red <= 1'b0;
    end else begin
      o_led_green <= 1'b1;
      if (fail_nxt) begin
        o_led_yellow <= 1'b0;
      end else if (sync2_ff[SY_NEAR]) begin
        o_led_yellow <= yel_phase_ff;
      end else begin
        o_led_yellow <= path2_nxt;
      end
      if (nxt_code == CODE_INTERNAL) begin
        o_led_red <= 1'b1;
      end else if (nxt_code == CODE_NONE) begin
        o_led_red <= 1'b0;
      end else begin
        o_led_red <= red_flash;
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  path_one_a: assert property (!$past(i_srst) |->
    o_primary_safe_out_a == ($past(act_s) && !fail_now))
    else $error("path one output mismatch");
  path_two_a: assert property (!$past(i_srst) |->
    o_lock_path_out_a == ($past(locked_s) && !fail_now))
    else $error("path two output mismatch");
  crit_off_a: assert property (crit_s |=>
    fail_now && !o_primary_safe_out_a && !o_lock_path_out_a)
    else $error("critical fault did not switch off");
  warn_hold_a: assert property ((state_ff == S_WARN) && !crit_s
    && !delay_done |=> o_primary_safe_out_a == $past(act_s))
    else $error("warning switched outputs off early");
  warn_expire_a: assert property ((state_ff == S_WARN) && warn_s
    && !crit_s && delay_done |=> state_ff == S_FAIL ##1 !o_primary_safe_out_a)
    else $error("warning delay did not expire into failure");
  warn_clear_a: assert property ((state_ff == S_WARN) && !fault_s
    |=> (state_ff == S_RUN) && (code_ff == CODE_NONE))
    else $error("warning did not clear");
  rearm_run_a: assert property ((state_ff == S_FAIL) && !fault_s
    && !act_s ##1 (state_ff == S_REARM) && act_s && !fault_s
    |=> state_ff == S_RUN)
    else $error("rearm did not return to run");
  red_steady_a: assert property ((state_ff == S_FAIL) &&
    (code_ff == CODE_INTERNAL) ##1 (state_ff == S_FAIL) |-> o_led_red)
    else $error("internal error red not steady");
  fail_lamp_a: assert property (fail_now && !$past(i_srst) |->
    !o_led_yellow && o_lock_path_out_b && !o_diag_out)
    else $error("failure state outputs wrong");
  green_on_a: assert property (!$past(i_srst) |-> o_led_green)
    else $error("green lamp off while ready");

  warn_back_c: cover property ((state_ff == S_WARN) ##1 (state_ff == S_RUN));
  warn_fail_c: cover property ((state_ff == S_WARN) ##1 (state_ff == S_FAIL));
  rearm_c: cover property ((state_ff == S_REARM) ##1 (state_ff == S_RUN));
  near_c: cover property (sync2_ff[SY_NEAR] && !fail_now && o_led_yellow);

endmodule // interlock_diag_controller

`default_nettype wire

// [tb/safety_plc_model.sv]
// plc model that watches the safety paths of the interlock
`timescale 1ns/10ps
`default_nettype none

module safety_plc_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // observed safety paths
  input wire logic i_path1_a,
  input wire logic i_path1_b,
  input wire logic i_path2_a,
  input wire logic i_path2_b,
  // restart permission
  output logic o_restart_ok
);
  logic chain_ff;

  // restart is allowed only while the locking chain stays locked
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      chain_ff <= 1'h0;
    end else begin
      chain_ff <= i_path1_a & i_path1_b & i_path2_a & ~i_path2_b;
    end
  end

  assign o_restart_ok = chain_ff;
endmodule // safety_plc_model

`default_nettype wire

// [tb/test_interlock_diag_controller.sv]
// self-checking bench for the interlock diagnostic controller
`timescale 1ns/10ps
`default_nettype none

module test_interlock_diag_controller
  import interlock_diag_pkg::*;
;
  // ----------------------------------------
  // setup
  // ----------------------------------------
  localparam int TCK = 2;
  localparam int WRN = 50;
  localparam int LIM = 40000;
  logic clk, srst, act, tgt, cond, near;
  logic [6:0] flt;
  logic pa, pb, la, lb, diag, grn, yel, red, rok;
  logic [7:0] outs;
  int fails, num_checks;

  assign outs = {pa, pb, la, lb, diag, grn, yel, red};

  interlock_diag_controller #(.TICK_CYC(TCK), .WARN_MS(WRN))
    i_interlock_diag_controller (
    .i_clk(clk), .i_srst(srst),
    .i_actuator_det(act), .i_lock_target_det(tgt),
    .i_lock_cond_det(cond), .i_near_limit(near),
    .i_test_fail_a(flt[0]), .i_test_fail_b(flt[1]),
    .i_cross_wire(flt[2]), .i_over_temp(flt[3]),
    .i_bad_actuator(flt[4]), .i_bad_target_combo(flt[5]),
    .i_internal_err(flt[6]),
    .o_primary_safe_out_a(pa), .o_primary_safe_out_b(pb),
    .o_lock_path_out_a(la), .o_lock_path_out_b(lb),
    .o_diag_out(diag), .o_led_green(grn),
    .o_led_yellow(yel), .o_led_red(red)
  );

  safety_plc_model i_safety_plc_model (
    .i_clk(clk), .i_srst(srst),
    .i_path1_a(pa), .i_path1_b(pb),
    .i_path2_a(la), .i_path2_b(lb),
    .o_restart_ok(rok)
  );

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic setin(input logic a, t, c, input logic [6:0] f);
    @(posedge clk);
    act <= a;
    tgt <= t;
    cond <= c;
    flt <= f;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t outputs %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      fails++;
      $display("BAD %0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic timeout;
    fails++;
    $display("BAD %0t wait ran out", $time);
    conclude();
  endtask

  // counts red pulses between two long pauses
  task automatic count_red(output int n);
    int low, c;
    logic prev;
    low = 0;
    c = 0;
    n = 0;
    while (low < 3 * RED_HALF_MS * TCK) begin
      cyc(1);
      c++;
      low = (red === 1'h0) ? low + 1 : 0;
      if (c > LIM) timeout();
    end
    low = 0;
    prev = red;
    while (low < 3 * RED_HALF_MS * TCK) begin
      cyc(1);
      c++;
      if (red === 1'h1 && prev !== 1'h1) n++;
      prev = red;
      low = (red === 1'h0) ? low + 1 : 0;
      if (c > LIM) timeout();
    end
  endtask

  task automatic rearm;
    setin(1'h0, 1'h1, 1'h1, 7'h00);
    cyc(5);
    setin(1'h1, 1'h1, 1'h1, 7'h00);
    cyc(5);
    chk(outs, 8'hEE);
    chk({7'h00, rok}, 8'h01);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_paths;
    for (int i = 0; i < 8; i++) begin
      setin(i[2], i[1], i[0], 7'h00);
      cyc(4);
      if (i[2] == 1'h0) begin
        chk(outs, 8'h14);
      end else if (i[1:0] == 2'h3) begin
        chk(outs, 8'hEE);
      end else begin
        chk(outs, 8'hD4);
      end
    end
  endtask

  task automatic t_near;
    int n;
    setin(1'h1, 1'h0, 1'h0, 7'h00);
    @(posedge clk) near <= 1'h1;
    cyc(6);
    n = 0;
    while (yel !== 1'h0 && n < 400) begin
      cyc(1);
      n++;
    end
    while (yel !== 1'h1 && n < 800) begin
      cyc(1);
      n++;
    end
    if (n >= 800) timeout();
    n = 0;
    while (yel === 1'h1 && n < 400) begin
      cyc(1);
      n++;
    end
    if (n >= 400) timeout();
    chk_n(n, YEL_HALF_MS * TCK);
    @(posedge clk) near <= 1'h0;
  endtask

  task automatic t_warn_clear;
    setin(1'h1, 1'h1, 1'h1, 7'h08);
    cyc(4);
    chk(outs & 8'hFE, 8'hEE);
    cyc(20);
    setin(1'h1, 1'h1, 1'h1, 7'h00);
    cyc(2 * TCK * WRN);
    chk(outs, 8'hEE);
  endtask

  task automatic t_fault(input logic [6:0] m, input int code, input int late);
    int n;
    setin(1'h1, 1'h1, 1'h1, m);
    cyc(4);
    chk(outs & 8'hFE, late ? 8'hEE : 8'h14);
    n = 0;
    while (pa !== 1'h0 && n < 4 * TCK * WRN) begin
      cyc(1);
      n++;
    end
    chk_n(n > TCK * WRN - 10 && n < 2 * TCK * WRN, late);
    chk(outs & 8'hFE, 8'h14);
    count_red(n);
    chk_n(n, code);
    setin(1'h1, 1'h1, 1'h1, 7'h00);
    cyc(10);
    chk(outs & 8'hFE, 8'h14);
    rearm();
  endtask

  task automatic t_internal;
    int n;
    setin(1'h1, 1'h1, 1'h1, 7'h40);
    cyc(4);
    chk(outs, 8'h15);
    n = 0;
    repeat (3 * RED_HALF_MS * TCK) begin
      cyc(1);
      if (red !== 1'h1) n++;
    end
    chk_n(n, 0);
    setin(1'h1, 1'h1, 1'h1, 7'h00);
    cyc(10);
    chk(outs, 8'h15);
    rearm();
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    fails = 0;
    num_checks = 0;
    srst = 1'h1;
    act = 1'h0;
    tgt = 1'h0;
    cond = 1'h0;
    near = 1'h0;
    flt = 7'h00;
    repeat (3) @(posedge clk);
    srst <= 1'h0;
    cyc(4);
    chk(outs, 8'h14);
    t_paths();
    t_near();
    t_warn_clear();
    t_fault(7'h01, 1, 1);
    t_fault(7'h02, 2, 1);
    t_fault(7'h04, 3, 1);
    t_fault(7'h03, 3, 1);
    t_fault(7'h08, 4, 1);
    t_fault(7'h10, 5, 0);
    t_fault(7'h20, 6, 0);
    t_internal();
    conclude();
  end
endmodule // test_interlock_diag_controller

`default_nettype wire
